// *** common/otr_pkg.sv ***
// Package for the offset and fine-scale trim register bank.
// Assumes a 32-bit APB slave port; register indices become byte addresses times four.
package otr_pkg;

  localparam int unsigned OTR_APB_ADDR_W  = 12;
  localparam int unsigned OTR_IDX_W       = 10;
  localparam int unsigned OTR_OFS_REG_W   = 16;
  localparam int unsigned OTR_SCALE_REG_W = 8;
  localparam int unsigned OTR_OFS_W       = 12;
  localparam int unsigned OTR_SCALE_W     = 5;
  localparam int unsigned OTR_NUM_OFS     = 5;
  localparam int unsigned OTR_NUM_SCALE   = 5;

  // Register indices as printed; byte address is index * 4
  localparam logic [9:0] OTR_IDX_CORE2_SECOND_INPUT_OFFSET = 10'h336;
  localparam logic [9:0] OTR_IDX_CORE3_THIRD_INPUT_OFFSET  = 10'h338;
  localparam logic [9:0] OTR_IDX_CORE3_FOURTH_INPUT_OFFSET = 10'h33a;
  localparam logic [9:0] OTR_IDX_CORE4_OFFSET_TRIM         = 10'h33c;
  localparam logic [9:0] OTR_IDX_CORE5_OFFSET_TRIM         = 10'h33e;
  localparam logic [9:0] OTR_IDX_CORE0_FINE_SCALE          = 10'h360;
  localparam logic [9:0] OTR_IDX_CORE1_FINE_SCALE          = 10'h361;
  localparam logic [9:0] OTR_IDX_CORE2_FIRST_INPUT_SCALE   = 10'h362;
  localparam logic [9:0] OTR_IDX_CORE2_SECOND_INPUT_SCALE  = 10'h363;
  localparam logic [9:0] OTR_IDX_CORE3_THIRD_INPUT_SCALE   = 10'h364;

  // Slot order inside the offset and scale arrays
  localparam logic [OTR_IDX_W-1:0] OTR_OFS_IDX [OTR_NUM_OFS] = '{
    OTR_IDX_CORE2_SECOND_INPUT_OFFSET,
    OTR_IDX_CORE3_THIRD_INPUT_OFFSET,
    OTR_IDX_CORE3_FOURTH_INPUT_OFFSET,
    OTR_IDX_CORE4_OFFSET_TRIM,
    OTR_IDX_CORE5_OFFSET_TRIM
  };
  localparam logic [OTR_IDX_W-1:0] OTR_SCALE_IDX [OTR_NUM_SCALE] = '{
    OTR_IDX_CORE0_FINE_SCALE,
    OTR_IDX_CORE1_FINE_SCALE,
    OTR_IDX_CORE2_FIRST_INPUT_SCALE,
    OTR_IDX_CORE2_SECOND_INPUT_SCALE,
    OTR_IDX_CORE3_THIRD_INPUT_SCALE
  };

  localparam int unsigned OTR_SLOT_C2_SECOND = 0;
  localparam int unsigned OTR_SLOT_C3_THIRD  = 1;
  localparam int unsigned OTR_SLOT_C3_FOURTH = 2;
  localparam int unsigned OTR_SLOT_C4        = 3;
  localparam int unsigned OTR_SLOT_C5        = 4;
  localparam int unsigned OTR_SLOT_G0        = 0;
  localparam int unsigned OTR_SLOT_G1        = 1;
  localparam int unsigned OTR_SLOT_G2_FIRST  = 2;
  localparam int unsigned OTR_SLOT_G2_SECOND = 3;
  localparam int unsigned OTR_SLOT_G3_THIRD  = 4;

  // Field positions and reset values
  localparam int unsigned OTR_OFS_LSB    = 0;
  localparam int unsigned OTR_SCALE_LSB  = 0;
  localparam logic [15:0] OTR_OFS_RESET   = 16'h0000;
  localparam logic [7:0]  OTR_SCALE_RESET = 8'h00;
  localparam logic [31:0] OTR_RDATA_RESET = 32'h0000_0000;

  typedef enum logic [1:0] {
    OTR_ST_WAIT_FUSE = 2'b00,
    OTR_ST_ACTIVE    = 2'b01
  } otr_state_t;

endpackage

// *** src/otr_trim_slot.sv ***
// One trim register: reset to a constant, loaded from fuse, then written by software.
// Assumes load and write never coincide; the caller sequences them.
`timescale 1ns/100ps
`default_nettype none
module otr_trim_slot
  import otr_pkg::*;
#(
  parameter int unsigned     W         = 16,
  parameter logic [W-1:0]    RESET_VAL = '0
)
(
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         load_en,
  input  wire logic [W-1:0] load_val,
  input  wire logic         wr_en,
  input  wire logic [W-1:0] wr_val,
  output logic      [W-1:0] value
);

  typedef struct packed {
    logic [W-1:0] value;
  } otr_slot_t;

  otr_slot_t state;
  otr_slot_t next_state;

  always_comb
  begin
    next_state = state;
    if (load_en)
    begin
      next_state.value = load_val;
    end
    else if (wr_en)
    begin
      // Whole word stored so reads return exactly what was written
      next_state.value = wr_val;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= '{value: RESET_VAL};
    end
    else
    begin
      state <= next_state;
    end
  end

  assign value = state.value;

endmodule
`default_nettype wire

// *** src/otr_trim_regs.sv ***
// Offset and fine-scale trim register bank with an APB slave port.
// Assumes fuse values and fuse_valid come from logic on pclk; input selects are async pins.
//
// Behaviour
// - Core two gets the second-pair offset only while it converts the second analog pair.
// - Core three gets the third-pair offset only while it converts the third analog pair.
// - Core three gets a separate fourth-pair offset while converting the fourth pair.
// - Core four always gets the offset held in bits eleven to zero of its register.
// - Core five always gets its own offset, regardless of any input selection.
// - Core zero is scaled by the five low bits of its eight-bit fine-scale register.
// - Core one is scaled by the five-bit value in its own fine-scale register.
// - Core two uses the first-pair scale for the first pair and the second for the second.
// - Core three uses its third-pair scale while converting the third pair.
// - Every trim register is initialised from fuse storage, not left at a constant.
// - Offset fields are unsigned binary values.
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module otr_trim_regs
  import otr_pkg::*;
(
  input  wire logic                                pclk,
  input  wire logic                                presetn,
  input  wire logic                                psel,
  input  wire logic                                penable,
  input  wire logic                                pwrite,
  input  wire logic [OTR_APB_ADDR_W-1:0]           paddr,
  input  wire logic [31:0]                         pwdata,
  output logic      [31:0]                         prdata,
  output logic                                     pready,
  output logic                                     pslverr,
  input  wire logic                                fuse_valid,
  input  wire logic [OTR_NUM_OFS*OTR_OFS_W-1:0]    fuse_offset,
  input  wire logic [OTR_NUM_SCALE*OTR_SCALE_W-1:0] fuse_scale,
  input  wire logic                                core2_input_sel,
  input  wire logic                                core3_input_sel,
  output logic                                     trim_loaded,
  output logic      [OTR_SCALE_W-1:0]              core0_scale,
  output logic      [OTR_SCALE_W-1:0]              core1_scale,
  output logic      [OTR_SCALE_W-1:0]              core2_scale,
  output logic      [OTR_OFS_W-1:0]                core2_offset,
  output logic                                     core2_offset_en,
  output logic      [OTR_OFS_W-1:0]                core3_offset,
  output logic      [OTR_SCALE_W-1:0]              core3_scale,
  output logic                                     core3_scale_en,
  output logic      [OTR_OFS_W-1:0]                core4_offset,
  output logic      [OTR_OFS_W-1:0]                core5_offset
);

  typedef struct packed {
    otr_state_t           fsm;
    logic                 sel2_meta;
    logic                 sel2;
    logic                 sel3_meta;
    logic                 sel3;
    logic [31:0]          rdata;
    logic                 slverr;
    logic [OTR_SCALE_W-1:0] g0;
    logic [OTR_SCALE_W-1:0] g1;
    logic [OTR_SCALE_W-1:0] g2;
    logic [OTR_OFS_W-1:0]   o2;
    logic                 o2_en;
    logic [OTR_OFS_W-1:0]   o3;
    logic [OTR_SCALE_W-1:0] g3;
    logic                 g3_en;
    logic [OTR_OFS_W-1:0]   o4;
    logic [OTR_OFS_W-1:0]   o5;
  } otr_regs_t;

  otr_regs_t state;
  otr_regs_t next_state;

  logic [OTR_OFS_REG_W-1:0]   ofs_q   [OTR_NUM_OFS];
  logic [OTR_SCALE_REG_W-1:0] scale_q [OTR_NUM_SCALE];
  logic [OTR_NUM_OFS-1:0]     ofs_hit;
  logic [OTR_NUM_SCALE-1:0]   scale_hit;
  logic [OTR_IDX_W-1:0]       req_idx;
  logic                       word_aligned;
  logic                       fuse_load;
  logic                       wr_fire;

  // Upper address bits select the word; the low two must be zero
  assign req_idx      = paddr[OTR_APB_ADDR_W-1:2];
  assign word_aligned = (paddr[1:0] == 2'b00);
  assign fuse_load    = (state.fsm == OTR_ST_WAIT_FUSE) && fuse_valid;
  // Bus is held off until fuse defaults are in, so software never races the load
  assign wr_fire      = psel && penable && pwrite && (state.fsm == OTR_ST_ACTIVE);

  genvar gi;
  generate
    for (gi = 0; gi < OTR_NUM_OFS; gi++)
    begin : g_ofs
      assign ofs_hit[gi] = word_aligned && (req_idx == OTR_OFS_IDX[gi]);
      otr_trim_slot #(
        .W         (OTR_OFS_REG_W),
        .RESET_VAL (OTR_OFS_RESET)
      ) u_slot (
        .pclk     (pclk),
        .presetn  (presetn),
        .load_en  (fuse_load),
        .load_val ({4'h0, fuse_offset[gi*OTR_OFS_W +: OTR_OFS_W]}),
        .wr_en    (wr_fire && ofs_hit[gi]),
        .wr_val   (pwdata[OTR_OFS_REG_W-1:0]),
        .value    (ofs_q[gi])
      );
    end
    for (gi = 0; gi < OTR_NUM_SCALE; gi++)
    begin : g_scale
      assign scale_hit[gi] = word_aligned && (req_idx == OTR_SCALE_IDX[gi]);
      otr_trim_slot #(
        .W         (OTR_SCALE_REG_W),
        .RESET_VAL (OTR_SCALE_RESET)
      ) u_slot (
        .pclk     (pclk),
        .presetn  (presetn),
        .load_en  (fuse_load),
        .load_val ({3'h0, fuse_scale[gi*OTR_SCALE_W +: OTR_SCALE_W]}),
        .wr_en    (wr_fire && scale_hit[gi]),
        .wr_val   (pwdata[OTR_SCALE_REG_W-1:0]),
        .value    (scale_q[gi])
      );
    end
  endgenerate

  always_comb
  begin
    next_state = state;

    case (state.fsm)
      OTR_ST_WAIT_FUSE:
      begin
        if (fuse_valid)
        begin
          next_state.fsm = OTR_ST_ACTIVE;
        end
      end
      OTR_ST_ACTIVE:
      begin
        next_state.fsm = OTR_ST_ACTIVE;
      end
      default:
      begin
        next_state.fsm = OTR_ST_WAIT_FUSE;
      end
    endcase

    // Two-flop synchronisers for the input-pair selects
    next_state.sel2_meta = core2_input_sel;
    next_state.sel2      = state.sel2_meta;
    next_state.sel3_meta = core3_input_sel;
    next_state.sel3      = state.sel3_meta;

    // Read data is captured every selected cycle, so the access phase sees
    // the word as it stood after any preceding write
    if (psel)
    begin
      next_state.rdata  = OTR_RDATA_RESET;
      next_state.slverr = 1'b1;
      for (int i = 0; i < OTR_NUM_OFS; i++)
      begin
        if (ofs_hit[i])
        begin
          next_state.rdata  = {16'h0000, ofs_q[i]};
          next_state.slverr = 1'b0;
        end
      end
      for (int i = 0; i < OTR_NUM_SCALE; i++)
      begin
        if (scale_hit[i])
        begin
          next_state.rdata  = {24'h000000, scale_q[i]};
          next_state.slverr = 1'b0;
        end
      end
    end

    // Applied corrections follow the stored words on the next edge
    next_state.g0    = scale_q[OTR_SLOT_G0][OTR_SCALE_LSB +: OTR_SCALE_W];
    next_state.g1    = scale_q[OTR_SLOT_G1][OTR_SCALE_LSB +: OTR_SCALE_W];
    next_state.g2    = state.sel2 ?
                       scale_q[OTR_SLOT_G2_SECOND][OTR_SCALE_LSB +: OTR_SCALE_W] :
                       scale_q[OTR_SLOT_G2_FIRST][OTR_SCALE_LSB +: OTR_SCALE_W];
    // First-pair offset of core two lives in another bank; here it reads zero
    next_state.o2_en = state.sel2;
    next_state.o2    = state.sel2 ?
                       ofs_q[OTR_SLOT_C2_SECOND][OTR_OFS_LSB +: OTR_OFS_W] :
                       12'h000;
    next_state.o3    = state.sel3 ?
                       ofs_q[OTR_SLOT_C3_FOURTH][OTR_OFS_LSB +: OTR_OFS_W] :
                       ofs_q[OTR_SLOT_C3_THIRD][OTR_OFS_LSB +: OTR_OFS_W];
    next_state.g3_en = !state.sel3;
    next_state.g3    = state.sel3 ?
                       5'h00 :
                       scale_q[OTR_SLOT_G3_THIRD][OTR_SCALE_LSB +: OTR_SCALE_W];
    // Offsets are passed as unsigned codes; no sign extension anywhere
    next_state.o4    = ofs_q[OTR_SLOT_C4][OTR_OFS_LSB +: OTR_OFS_W];
    next_state.o5    = ofs_q[OTR_SLOT_C5][OTR_OFS_LSB +: OTR_OFS_W];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= '{
        fsm:       OTR_ST_WAIT_FUSE,
        sel2_meta: 1'b0,
        sel2:      1'b0,
        sel3_meta: 1'b0,
        sel3:      1'b0,
        rdata:     OTR_RDATA_RESET,
        slverr:    1'b0,
        g0:        5'h00,
        g1:        5'h00,
        g2:        5'h00,
        o2:        12'h000,
        o2_en:     1'b0,
        o3:        12'h000,
        g3:        5'h00,
        g3_en:     1'b0,
        o4:        12'h000,
        o5:        12'h000
      };
    end
    else
    begin
      state <= next_state;
    end
  end

  // Stall only while fuse defaults are pending; zero wait states afterwards
  assign pready          = (state.fsm == OTR_ST_ACTIVE);
  assign prdata          = state.rdata;
  assign pslverr         = state.slverr && psel && penable && pready;
  assign trim_loaded     = (state.fsm == OTR_ST_ACTIVE);
  assign core0_scale     = state.g0;
  assign core1_scale     = state.g1;
  assign core2_scale     = state.g2;
  assign core2_offset    = state.o2;
  assign core2_offset_en = state.o2_en;
  assign core3_offset    = state.o3;
  assign core3_scale     = state.g3;
  assign core3_scale_en  = state.g3_en;
  assign core4_offset    = state.o4;
  assign core5_offset    = state.o5;

endmodule
`default_nettype wire

// *** verif/otr_trim_regs_chk.sv ***
// Concurrent checks on the trim register bank's ports.
// Assumes one pclk domain; bound into every instance of the bank.
`timescale 1ns/100ps
`default_nettype none
module otr_trim_regs_chk
  import otr_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        fuse_valid,
  input wire logic        core2_input_sel,
  input wire logic        core3_input_sel,
  input wire logic        trim_loaded,
  input wire logic [4:0]  core0_scale,
  input wire logic [4:0]  core1_scale,
  input wire logic [11:0] core2_offset,
  input wire logic        core2_offset_en,
  input wire logic [4:0]  core3_scale,
  input wire logic        core3_scale_en,
  input wire logic [11:0] core4_offset,
  input wire logic [11:0] core5_offset
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Output follows one edge after the write edge
  property p_wr(idx, outv, m);
    psel && penable && pready && pwrite && paddr == {idx, 2'b00}
      |-> ##2 32'(outv) == ($past(pwdata, 2) & m);
  endproperty

  a_fuse_load_once: assert property (fuse_valid && !trim_loaded |=> trim_loaded && pready)
    else $error("fuse load not taken");
  a_wait_no_ready: assert property (!trim_loaded |-> !pready)
    else $error("ready before fuse load");
  a_loaded_holds: assert property (trim_loaded |=> trim_loaded)
    else $error("loaded flag dropped");
  a_core4_write: assert property (p_wr(OTR_IDX_CORE4_OFFSET_TRIM, core4_offset, 32'hfff))
    else $error("core4 offset missed write");
  a_core5_write: assert property (p_wr(OTR_IDX_CORE5_OFFSET_TRIM, core5_offset, 32'hfff))
    else $error("core5 offset missed write");
  a_scale0_write: assert property (p_wr(OTR_IDX_CORE0_FINE_SCALE, core0_scale, 32'h1f))
    else $error("core0 scale missed write");
  a_scale1_write: assert property (p_wr(OTR_IDX_CORE1_FINE_SCALE, core1_scale, 32'h1f))
    else $error("core1 scale missed write");
  a_core2_sel_rise: assert property (trim_loaded && $rose(core2_input_sel)
    |-> ##2 !core2_offset_en ##1 core2_offset_en) else $error("core2 select latency");
  a_core2_ofs_gate: assert property (!core2_offset_en |-> core2_offset == 12'h000)
    else $error("core2 offset outside second pair");
  a_core3_sel_fall: assert property (trim_loaded && $fell(core3_input_sel)
    |-> ##2 !core3_scale_en ##1 core3_scale_en) else $error("core3 select latency");
  a_core3_scl_gate: assert property (!core3_scale_en |-> core3_scale == 5'h00)
    else $error("core3 scale outside third pair");

  c_write: cover property (psel && penable && pready && pwrite);
  c_sel2: cover property (trim_loaded && $rose(core2_input_sel));
  c_error: cover property (pslverr && pready);
endmodule

bind otr_trim_regs otr_trim_regs_chk otr_trim_regs_chk_inst (.*);
`default_nettype wire

// *** verif/tb.sv ***
// Self-checking bench for the trim register bank, APB master plus model.
// Assumes fuse inputs and input selects are driven here on pclk.
`timescale 1ns/100ps
`default_nettype none
module tb
  import otr_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, fuse_valid;
  logic        core2_input_sel, core3_input_sel, trim_loaded, core2_offset_en, core3_scale_en;
  logic [11:0] paddr, core2_offset, core3_offset, core4_offset, core5_offset;
  logic [31:0] pwdata, prdata, r;
  logic [59:0] fuse_offset;
  logic [24:0] fuse_scale;
  logic [4:0]  core0_scale, core1_scale, core2_scale, core3_scale;
  logic        e;
  int          miscompares = 0, cmp_count = 0, cyc = 0, seed = 54, model[10];

  otr_trim_regs otr_trim_regs_inst (.*);

  initial
  begin
    pclk = 0;
    forever #2.5 pclk = ~pclk;
  end

  task automatic report_and_stop;
    if (miscompares == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge pclk)
  begin
    cyc++;
    // Whole run needs well under a thousand cycles
    if (cyc == 5000)
    begin
      miscompares++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    cmp_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  function automatic logic [11:0] adr(input int i);
    adr = {(i < 5) ? OTR_OFS_IDX[i] : OTR_SCALE_IDX[i - 5], 2'b00};
  endfunction

  task automatic check_cores;
    int s2;
    int s3;
    s2 = int'(core2_input_sel);
    s3 = int'(core3_input_sel);
    chk(32'(core0_scale), 32'(model[5]), "core0_scale");
    chk(32'(core1_scale), 32'(model[6]), "core1_scale");
    chk(32'(core2_scale), 32'(s2 ? model[8] : model[7]), "core2_scale");
    chk(32'(core2_offset), 32'(s2 ? model[0] : 0), "core2_offset");
    chk(32'(core2_offset_en), 32'(s2), "core2_offset_en");
    chk(32'(core3_offset), 32'(s3 ? model[2] : model[1]), "core3_offset");
    chk(32'(core3_scale), 32'(s3 ? 0 : model[9]), "core3_scale");
    chk(32'(core3_scale_en), 32'(!s3), "core3_scale_en");
    chk(32'(core4_offset), 32'(model[3]), "core4_offset");
    chk(32'(core5_offset), 32'(model[4]), "core5_offset");
  endtask

  task automatic check_all;
    for (int i = 0; i < 10; i++)
    begin
      apb(1'b0, adr(i), 32'h0, r, e);
      chk(r, 32'(model[i]), "readback");
      chk(32'(e), 32'h0, "pslverr");
    end
    check_cores();
  endtask

  initial
  begin
    presetn = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 0;
    pwdata = 0;
    fuse_valid = 0;
    core2_input_sel = 0;
    core3_input_sel = 0;
    fuse_offset = 60'({$random(seed), $random(seed)});
    fuse_scale = 25'($random(seed));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(32'(pready), 32'h0, "pready before load");
    chk(32'(trim_loaded), 32'h0, "trim_loaded before load");
    fuse_valid <= 1'b1;
    @(posedge pclk);
    fuse_valid <= 1'b0;
    for (int i = 0; i < 5; i++)
    begin
      model[i] = int'(fuse_offset[i*12 +: 12]);
      model[i + 5] = int'(fuse_scale[i*5 +: 5]);
    end
    // A second fuse pulse must not reload the bank
    fuse_offset <= ~fuse_offset;
    fuse_scale <= ~fuse_scale;
    repeat (2) @(posedge pclk);
    fuse_valid <= 1'b1;
    @(posedge pclk);
    fuse_valid <= 1'b0;
    chk(32'(trim_loaded), 32'h1, "trim_loaded after load");
    check_all();
    repeat (3)
    begin
      for (int i = 0; i < 10; i++)
      begin
        model[i] = $random(seed) & ((i < 5) ? 'hfff : 'h1f);
        // No calibration engine runs in this bench, so offset slots are always open
        apb(1'b1, adr(i), 32'(model[i]), r, e);
      end
      check_all();
    end
    for (int k = 0; k < 5; k++)
    begin
      core2_input_sel <= k[0];
      core3_input_sel <= k[1];
      repeat (4) @(posedge pclk);
      check_cores();
    end
    apb(1'b0, 12'hffc, 32'h0, r, e);
    chk(32'(e), 32'h1, "unmapped pslverr");
    chk(r, 32'h0, "unmapped read");
    apb(1'b1, adr(3) | 12'h001, 32'h0000_0abc, r, e);
    chk(32'(e), 32'h1, "misaligned pslverr");
    check_all();
    report_and_stop();
  end
endmodule
`default_nettype wire
